// ### core/tpw_prescaler.sv
// ============================================================
// Prescaler: turns the I/O clock into a timer tick enable.
// Assumes the select code comes from logic on the same clock.
// ============================================================
`timescale 1ns/1ps
module tpw_prescaler (
  input wire logic aclk,  // I/O clock
  input wire logic aresetn,  // Synchronous reset, active low
  input wire logic [2:0] clk_sel,  // Clock select code, 0 stops
  output logic tick  // One-cycle timer clock enable
);
  import tpw_pkg::*;

  typedef struct packed {
    logic [9:0] div;  // Free-running divider
  } tpw_ps_state_type;

  tpw_ps_state_type s_ff;  // Registered state
  tpw_ps_state_type nxt_s;  // Next state
  logic [9:0] mask;  // Divider mask for this select

  // ============================================================
  // Divider; shared by all rates so a rate change needs no restart
  always_comb begin
    nxt_s = s_ff;
    nxt_s.div = s_ff.div + 10'h001;
    mask = ps_mask(clk_sel);
    // Tick when the low bits wrap; select 1 ticks every cycle
    tick = (clk_sel != 3'h0) && ((s_ff.div & mask) == mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

// ### core/tpw_pwm_timer.sv
// ============================================================
// 16-bit timer with fast and phase correct PWM on three channels.
// Assumes an AXI4-Lite master on aclk; pins go to pad logic.
// ============================================================
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tpw_pwm_timer #(
  parameter int NUM_CH = tpw_pkg::NCH  // Compare channels
) (
  input wire logic aclk,  // I/O clock, 250 MHz
  input wire logic aresetn,  // Synchronous reset, active low
  input wire logic [tpw_pkg::AW-1:0] s_axi_awaddr,  // Write address
  input wire logic s_axi_awvalid,  // Write address valid
  output logic s_axi_awready,  // Write address ready
  input wire logic [31:0] s_axi_wdata,  // Write data
  input wire logic [3:0] s_axi_wstrb,  // Byte enables
  input wire logic s_axi_wvalid,  // Write data valid
  output logic s_axi_wready,  // Write data ready
  output logic [1:0] s_axi_bresp,  // Write response
  output logic s_axi_bvalid,  // Write response valid
  input wire logic s_axi_bready,  // Write response ready
  input wire logic [tpw_pkg::AW-1:0] s_axi_araddr,  // Read address
  input wire logic s_axi_arvalid,  // Read address valid
  output logic s_axi_arready,  // Read address ready
  output logic [31:0] s_axi_rdata,  // Read data
  output logic [1:0] s_axi_rresp,  // Read response
  output logic s_axi_rvalid,  // Read data valid
  input wire logic s_axi_rready,  // Read data ready
  output logic [NUM_CH-1:0] compare_output_pin_o,  // Pin levels
  output logic [NUM_CH-1:0] compare_output_pin_oe  // Pin drive enables
);
  import tpw_pkg::*;

  // ============================================================
  // State
  typedef struct packed {
    logic [15:0] counter_value;  // Timer count
    logic count_up;  // Dual slope direction
    logic [NUM_CH-1:0][15:0] cmp_act;  // Active compare values
    logic [NUM_CH-1:0][15:0] compare_value_reg;  // Compare buffers
    logic [15:0] capture_top_reg;  // Capture register
    logic [3:0] waveform_mode_sel;  // Waveform mode
    logic [2:0] clk_sel;  // Prescaler select
    logic [NUM_CH-1:0][1:0] compare_output_mode;  // Output mode per channel
    logic [NUM_CH-1:0] pin_direction_bit;  // Pin is output
    logic [NUM_CH-1:0] level;  // Compare output levels
    logic overflow_flag;  // Sticky overflow
    logic [NUM_CH-1:0] match_flag;  // Sticky compare matches
    logic capture_flag;  // Sticky capture / TOP flag
    logic [NUM_CH-1:0] pin_o;  // Pin level register
    logic [NUM_CH-1:0] pin_oe;  // Pin enable register
    logic awready;  // Bus handshake registers
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;  // Write address held
    logic [AW-1:0] aw_addr;
    logic w_have;  // Write data held
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } tpw_state_type;

  tpw_state_type s_ff;  // Registered state
  tpw_state_type nxt_s;  // Next state

  logic tick;  // Timer clock enable
  logic [15:0] top;  // Current TOP
  logic at_top;  // Counter equals TOP
  logic wrap;  // Fast mode wrap tick
  logic load;  // Buffer transfer tick
  logic eff_up;  // Direction a match is judged by
  logic match;  // Per-channel match in loop
  logic do_wr;  // Write performed this cycle
  logic wr_ok;  // Write address mapped
  logic [31:0] wd;  // Write data merged with byte enables
  logic [31:0] old;  // Register value before the write
  logic [NUM_CH-1:0] ocf_set;  // Compare flag sets
  logic [NUM_CH-1:0] ocf_clr;  // Compare flag clears
  logic tov_set;  // Overflow set
  logic tov_clr;  // Overflow clear
  logic icf_set;  // Capture flag set
  logic icf_clr;  // Capture flag clear

  // ============================================================
  // Prescaler
  tpw_prescaler u_ps (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(s_ff.clk_sel),
    .tick(tick)
  );

  // Byte-enable merge
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // TOP selected by the waveform mode
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cap,
                                         input logic [15:0] cmpa);
    case (m)
      WGM_PC_CAP, WGM_FP_CAP: return cap;
      WGM_PC_A, WGM_FP_A: return cmpa;
      default: return fixed_mask(m);
    endcase
  endfunction

  // Register read view
  function automatic logic [31:0] reg_view(input tpw_state_type s, input logic [AW-1:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      REG_CTRL: begin
        r[CTRL_WGM_LSB +: 4] = s.waveform_mode_sel;
        r[CTRL_CS_LSB +: 3] = s.clk_sel;
        r[CTRL_COM_LSB +: 2*NUM_CH] = s.compare_output_mode;
      end
      REG_CAPTOP: r[15:0] = s.capture_top_reg;
      REG_DIR: r[NUM_CH-1:0] = s.pin_direction_bit;
      REG_STAT: begin
        r[STAT_TOV] = s.overflow_flag;
        r[STAT_OCF_LSB +: NUM_CH] = s.match_flag;
        r[STAT_ICF] = s.capture_flag;
      end
      REG_COUNT: r[15:0] = s.counter_value;
      default: begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (a == REG_CMP0 + AW'(4 * c)) begin
            r[15:0] = s.compare_value_reg[c];
          end
        end
      end
    endcase
    return r;
  endfunction

  // Address map check
  function automatic logic mapped(input logic [AW-1:0] a);
    logic m;
    m = a inside {REG_CTRL, REG_CAPTOP, REG_DIR, REG_STAT, REG_COUNT};
    for (int c = 0; c < NUM_CH; c++) begin
      if (a == REG_CMP0 + AW'(4 * c)) begin
        m = 1'b1;
      end
    end
    return m;
  endfunction

  // ============================================================
  // Next-state logic: timer, then bus, then flag merge
  always_comb begin
    nxt_s = s_ff;
    ocf_set = '0;
    ocf_clr = '0;
    tov_set = 1'b0;
    tov_clr = 1'b0;
    icf_set = 1'b0;
    icf_clr = 1'b0;
    wrap = 1'b0;
    load = 1'b0;
    match = 1'b0;
    top = top_of(s_ff.waveform_mode_sel, s_ff.capture_top_reg, s_ff.cmp_act[0]);
    at_top = (s_ff.counter_value == top);
    // A match at TOP counts as falling and at BOTTOM as rising, so the extremes hold
    eff_up = (s_ff.counter_value == ZERO16) || (s_ff.count_up && !at_top);

    // ----- Counter, only on timer ticks
    if (tick && is_fast(s_ff.waveform_mode_sel)) begin
      wrap = at_top;
      load = at_top;
      tov_set = at_top;
      // Clear on the tick after TOP is reached
      nxt_s.counter_value = at_top ? ZERO16 : s_ff.counter_value + 16'h0001;
    end else if (tick && is_dual(s_ff.waveform_mode_sel)) begin
      if (s_ff.count_up) begin
        if (at_top) begin
          // TOP was held for this one tick; turn round
          nxt_s.count_up = 1'b0;
          nxt_s.counter_value = s_ff.counter_value - 16'h0001;
          load = 1'b1;
        end else begin
          nxt_s.counter_value = s_ff.counter_value + 16'h0001;
        end
      end else if (s_ff.counter_value == ZERO16) begin
        nxt_s.count_up = 1'b1;
        nxt_s.counter_value = 16'h0001;
        tov_set = 1'b1;
      end else begin
        nxt_s.counter_value = s_ff.counter_value - 16'h0001;
      end
    end

    // ----- Flags raised at TOP when a register defines it
    if (load) begin
      icf_set = s_ff.waveform_mode_sel inside {WGM_PC_CAP, WGM_FP_CAP};
      ocf_set[0] = s_ff.waveform_mode_sel inside {WGM_PC_A, WGM_FP_A};
      nxt_s.cmp_act = s_ff.compare_value_reg;
    end

    // ----- Compare outputs; active values before this tick's load
    if (tick && (is_fast(s_ff.waveform_mode_sel) || is_dual(s_ff.waveform_mode_sel))) begin
      for (int c = 0; c < NUM_CH; c++) begin
        match = (s_ff.counter_value == s_ff.cmp_act[c]);
        if (match) begin
          ocf_set[c] = 1'b1;
        end
        case (s_ff.compare_output_mode[c])
          COM_TOGGLE: begin
            // Toggle only on channel A with A as TOP; gives 50% duty
            if (c == 0 && match &&
                s_ff.waveform_mode_sel inside {WGM_FP_A, WGM_PC_A}) begin
              nxt_s.level[c] = !s_ff.level[c];
            end
          end
          COM_NONINV, COM_INV: begin
            if (is_fast(s_ff.waveform_mode_sel)) begin
              // Wrap beats match so compare at TOP stays constant
              if (wrap) begin
                nxt_s.level[c] = (s_ff.compare_output_mode[c] == COM_NONINV);
              end else if (match) begin
                nxt_s.level[c] = (s_ff.compare_output_mode[c] == COM_INV);
              end
            end else if (match) begin
              // Non-inverted clears rising, sets falling
              nxt_s.level[c] = (s_ff.compare_output_mode[c] == COM_NONINV) ^ eff_up;
            end
          end
          default: begin
            // No waveform; level holds and still drives the pin while set as output
          end
        endcase
      end
    end

    // ----- Bus write channel capture
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_have = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_have = 1'b1;
      nxt_s.wdata = s_axi_wdata;
      nxt_s.wstrb = s_axi_wstrb;
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    do_wr = nxt_s.aw_have && nxt_s.w_have && !s_ff.bvalid;
    wr_ok = mapped(nxt_s.aw_addr);
    old = reg_view(s_ff, nxt_s.aw_addr);
    wd = merge(old, nxt_s.wdata, nxt_s.wstrb);

    // ----- Register writes; software wins over the timer for the count
    if (do_wr) begin
      nxt_s.aw_have = 1'b0;
      nxt_s.w_have = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      case (nxt_s.aw_addr)
        REG_CTRL: begin
          nxt_s.waveform_mode_sel = wd[CTRL_WGM_LSB +: 4];
          nxt_s.clk_sel = wd[CTRL_CS_LSB +: 3];
          nxt_s.compare_output_mode = wd[CTRL_COM_LSB +: 2*NUM_CH];
        end
        REG_CAPTOP: nxt_s.capture_top_reg = wd[15:0];
        REG_DIR: nxt_s.pin_direction_bit = wd[NUM_CH-1:0];
        REG_STAT: begin
          tov_clr = nxt_s.wstrb[0] && nxt_s.wdata[STAT_TOV];
          ocf_clr = nxt_s.wstrb[0] ? nxt_s.wdata[STAT_OCF_LSB +: NUM_CH] : '0;
          icf_clr = nxt_s.wstrb[0] && nxt_s.wdata[STAT_ICF];
        end
        REG_COUNT: nxt_s.counter_value = wd[15:0];
        default: begin
          for (int c = 0; c < NUM_CH; c++) begin
            if (nxt_s.aw_addr == REG_CMP0 + AW'(4 * c)) begin
              // Bits above a fixed resolution are forced to zero
              nxt_s.compare_value_reg[c] = wd[15:0] & fixed_mask(s_ff.waveform_mode_sel);
              // Modes without double buffering take the value at once
              if (!is_fast(s_ff.waveform_mode_sel) && !is_dual(s_ff.waveform_mode_sel)) begin
                nxt_s.cmp_act[c] = wd[15:0];
              end
            end
          end
        end
      endcase
    end
    nxt_s.awready = !nxt_s.aw_have && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_have && !nxt_s.bvalid;

    // ----- Bus read channel; data caught at the address handshake
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = reg_view(s_ff, s_axi_araddr);
      nxt_s.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_s.arready = !nxt_s.rvalid;

    // ----- Sticky flags: a set in the clearing cycle survives
    nxt_s.overflow_flag = (s_ff.overflow_flag && !tov_clr) || tov_set;
    nxt_s.match_flag = (s_ff.match_flag & ~ocf_clr) | ocf_set;
    nxt_s.capture_flag = (s_ff.capture_flag && !icf_clr) || icf_set;

    // ----- Pins follow the level only while set as output
    nxt_s.pin_oe = nxt_s.pin_direction_bit;
    nxt_s.pin_o = nxt_s.level & nxt_s.pin_direction_bit;
  end

  // ============================================================
  // State register; reset clears counter, levels and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.count_up <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ============================================================
  // Outputs straight from the state register
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rresp = s_ff.rresp;
  assign s_axi_rdata = s_ff.rdata;
  assign compare_output_pin_o = s_ff.pin_o;
  assign compare_output_pin_oe = s_ff.pin_oe;
endmodule

// ### pkg/tpw_pkg.sv
// ============================================================
// Constants, register map and shared decoders of the PWM timer.
// Assumes a 32-bit AXI4-Lite master and one 250 MHz clock.
// ============================================================
package tpw_pkg;
  // ============================================================
  // Sizes
  localparam int NCH = 3;  // Compare channels A, B, C
  localparam int AW = 8;  // Byte address width
  // ============================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;  // Mode, prescale, output modes
  localparam logic [7:0] REG_CAPTOP = 8'h04;  // Capture register used as TOP
  localparam logic [7:0] REG_CMP0 = 8'h08;  // Channel A; B and C follow by 4
  localparam logic [7:0] REG_DIR = 8'h14;  // Pin direction bits
  localparam logic [7:0] REG_STAT = 8'h18;  // Sticky flags, write one to clear
  localparam logic [7:0] REG_COUNT = 8'h1c;  // Counter value
  // ============================================================
  // Field positions
  localparam int CTRL_WGM_LSB = 0;  // Waveform mode, 4 bits
  localparam int CTRL_CS_LSB = 4;  // Clock select, 3 bits
  localparam int CTRL_COM_LSB = 8;  // Output modes, 2 bits per channel
  localparam int STAT_TOV = 0;  // Overflow flag
  localparam int STAT_OCF_LSB = 1;  // Compare flags, one per channel
  localparam int STAT_ICF = 4;  // Capture flag
  // ============================================================
  // Waveform modes handled here
  localparam logic [3:0] WGM_PC8 = 4'h1;
  localparam logic [3:0] WGM_PC9 = 4'h2;
  localparam logic [3:0] WGM_PC10 = 4'h3;
  localparam logic [3:0] WGM_FP8 = 4'h5;
  localparam logic [3:0] WGM_FP9 = 4'h6;
  localparam logic [3:0] WGM_FP10 = 4'h7;
  localparam logic [3:0] WGM_PC_CAP = 4'ha;
  localparam logic [3:0] WGM_PC_A = 4'hb;
  localparam logic [3:0] WGM_FP_CAP = 4'he;
  localparam logic [3:0] WGM_FP_A = 4'hf;
  // Output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;
  // TOP values
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [15:0] TOP_FULL = 16'hffff;
  // Clock select codes and prescaler masks (divide by mask plus one)
  localparam logic [2:0] CS_1 = 3'h1;
  localparam logic [2:0] CS_8 = 3'h2;
  localparam logic [2:0] CS_64 = 3'h3;
  localparam logic [2:0] CS_256 = 3'h4;
  localparam logic [2:0] CS_1024 = 3'h5;
  localparam logic [9:0] PS_M8 = 10'h007;
  localparam logic [9:0] PS_M64 = 10'h03f;
  localparam logic [9:0] PS_M256 = 10'h0ff;
  localparam logic [9:0] PS_M1024 = 10'h3ff;
  // Bus answers and reset values
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // ============================================================
  // Shared decoders
  function automatic logic is_fast(input logic [3:0] m);
    return m inside {WGM_FP8, WGM_FP9, WGM_FP10, WGM_FP_CAP, WGM_FP_A};
  endfunction
  function automatic logic is_dual(input logic [3:0] m);
    return m inside {WGM_PC8, WGM_PC9, WGM_PC10, WGM_PC_CAP, WGM_PC_A};
  endfunction
  // Resolution mask of the fixed-TOP modes; full width otherwise
  function automatic logic [15:0] fixed_mask(input logic [3:0] m);
    case (m)
      WGM_PC8, WGM_FP8: return TOP_8;
      WGM_PC9, WGM_FP9: return TOP_9;
      WGM_PC10, WGM_FP10: return TOP_10;
      default: return TOP_FULL;
    endcase
  endfunction
  function automatic logic [9:0] ps_mask(input logic [2:0] cs);
    case (cs)
      CS_8: return PS_M8;
      CS_64: return PS_M64;
      CS_256: return PS_M256;
      CS_1024: return PS_M1024;
      default: return 10'h000;
    endcase
  endfunction
endpackage

// ### tb/test_timer16_fast_and_phase_pwm.sv
// Bench of the PWM timer: bus tasks, load model, waveform checks.
// Assumes design, load model and checker are compiled before it.
`timescale 1ns/1ps
module test_timer16_fast_and_phase_pwm;
  import tpw_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, clr = 1'h0, saw_hi, saw_lo;
  logic [1:0] bresp, rresp;
  logic [1:0] sel = 2'h0;
  logic [31:0] rdata;
  logic [2:0] pin_o, pin_oe;
  int period, high, rises, mismatches = 0, n_checks = 0;
  int ns [5] = '{1, 8, 64, 256, 1024};
  initial begin forever #2 aclk = ~aclk; end
  tpw_pwm_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .compare_output_pin_o(pin_o), .compare_output_pin_oe(pin_oe));
  tpw_load u_load (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .sel(sel), .clr(clr),
    .period(period), .high(high), .rises(rises), .saw_hi(saw_hi), .saw_lo(saw_lo));
  // ==========
  // Shared compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p, w_p;
    aw_p = 1'h1;
    w_p = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // Each channel is released on its own handshake
    while (aw_p || w_p) begin
      @(posedge aclk);
      aw_p = aw_p && !awready;
      w_p = w_p && !wready;
      awvalid <= aw_p;
      wvalid <= w_p;
    end
    do @(posedge aclk); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, (a > REG_COUNT) ? RESP_SLVERR : RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, (a > REG_COUNT) ? RESP_SLVERR : RESP_OKAY});
  endtask
  // Halted set-up; compare writes in mode 0 go straight to the active value
  task automatic cfg(input int ch, input logic [3:0] m, input logic [2:0] cs,
                     input logic [1:0] com, input logic [15:0] top, input logic [15:0] cmp);
    wr(REG_CTRL, 32'h0000_0000);  // Halt, so TOP never moves mid-count
    wr(REG_COUNT, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(REG_CMP0 + 8'(4 * i), {16'h0000, (i == ch) ? cmp : top});  // Within TOP
    end
    wr(REG_CAPTOP, {16'h0000, top});
    wr(REG_DIR, 32'(1 << ch));
    wr(REG_CTRL, 32'(m) | (32'(cs) << CTRL_CS_LSB) | (32'(com) << (CTRL_COM_LSB + 2 * ch)));
    sel <= 2'(ch);
  endtask
  // Skip the settling periods, then judge the last whole one
  task automatic meas(input int p, input int h);
    int r0;
    r0 = rises;
    repeat (60000) if (rises < r0 + 3) @(posedge aclk);
    chk(32'(rises - r0), 32'h3);
    chk(32'(period), 32'(p));
    chk(32'(high), 32'(h));
  endtask
  task automatic steady(input logic lv);
    repeat (40) @(posedge aclk);
    clr <= 1'h1;
    @(posedge aclk);
    clr <= 1'h0;
    repeat (100) @(posedge aclk);
    chk({31'h0, saw_hi}, {31'h0, lv});
    chk({31'h0, saw_lo}, {31'h0, !lv});
  endtask
  // Stop the timer, read flags, clear them by writing ones
  task automatic flags(input logic [31:0] exp);
    wr(REG_CTRL, 32'h0000_0000);
    rd(REG_STAT, exp);
    wr(REG_STAT, 32'h0000_001f);
    rd(REG_STAT, 32'h0000_0000);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========
  // Watchdog: the tests need about 60k cycles
  initial begin
    #360000;
    mismatches++;
    complete_run();
  end
  // ==========
  // Test sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(REG_CTRL, 32'h0000_0000);
    rd(REG_COUNT, 32'h0000_0000);
    rd(REG_STAT, 32'h0000_0000);
    wr(8'h20, 32'h0000_ffff);
    rd(8'h20, 32'h0000_0000);
    $display("test reset done");
    for (int k = 0; k < 5; k++) begin
      cfg(1, WGM_FP_CAP, 3'(CS_1 + k), COM_NONINV, 16'h0009, 16'h0003);
      meas(10 * ns[k], 4 * ns[k]);
    end
    cfg(2, WGM_FP_CAP, CS_1, COM_INV, 16'h0009, 16'h0003);
    meas(10, 6);
    cfg(1, WGM_FP_CAP, CS_1, COM_NONINV, 16'h0009, 16'h0000);
    meas(10, 1);
    cfg(1, WGM_FP_CAP, CS_1, COM_NONINV, 16'h0009, 16'h0009);
    steady(1'h1);
    cfg(1, WGM_FP_CAP, CS_1, COM_INV, 16'h0009, 16'h0009);
    steady(1'h0);
    cfg(1, WGM_FP_CAP, CS_1, COM_NONINV, 16'h0003, 16'h0001);
    meas(4, 2);
    cfg(0, WGM_FP_A, CS_1, COM_TOGGLE, 16'h0000, 16'h0000);
    meas(2, 1);
    wr(REG_DIR, 32'h0000_0000);
    steady(1'h0);
    chk({29'h0, pin_oe}, 32'h0000_0000);
    $display("test fast done");
    cfg(1, WGM_PC_CAP, CS_1, COM_NONINV, 16'h0009, 16'h0003);
    meas(18, 6);
    flags(32'h0000_001f);
    cfg(2, WGM_PC_CAP, CS_1, COM_INV, 16'h0009, 16'h0003);
    meas(18, 12);
    cfg(1, WGM_PC_CAP, CS_1, COM_NONINV, 16'h0009, 16'h0000);
    steady(1'h0);
    cfg(1, WGM_PC_CAP, CS_1, COM_NONINV, 16'h0009, 16'h0009);
    steady(1'h1);
    cfg(0, WGM_PC_A, CS_1, COM_TOGGLE, 16'h0004, 16'h0004);
    meas(16, 8);
    flags(32'h0000_001f);
    $display("test dual done");
    for (int k = 0; k < 3; k++) begin
      wr(REG_CTRL, 32'(1 + k));
      wr(REG_CMP0, 32'h0000_abcd);
      rd(REG_CMP0, 32'h0000_abcd & ((32'h0000_0100 << k) - 1));
      cfg(1, 4'(1 + k), CS_1, COM_NONINV, 16'h0000, 16'h0064);
      meas(2 * ((256 << k) - 1), 200);
      cfg(1, 4'(5 + k), CS_1, COM_NONINV, 16'h0000, 16'h0064);
      meas(256 << k, 101);
    end
    flags(32'h0000_000f);
    $display("test fixed done");
    complete_run();
  end
endmodule

// ### tb/tpw_load.sv
// External load on the PWM pins: measures period and high time.
// Assumes a pull-down, so a released pin reads low.
`timescale 1ns/1ps
module tpw_load (
  input wire logic aclk,  // Clock
  input wire logic [2:0] pin_o,  // Pin levels
  input wire logic [2:0] pin_oe,  // Drive enables
  input wire logic [1:0] sel,  // Watched channel
  input wire logic clr,  // Clears sticky levels
  output int period,  // Cycles between rises
  output int high,  // High cycles of last period
  output int rises,  // Rising edges seen
  output logic saw_hi,  // High seen since clear
  output logic saw_lo  // Low seen since clear
);
  logic lvl;
  logic prev = 1'h0;
  int since = 0;
  int hcnt = 0;
  // Undriven pin settles low through the pull-down
  assign lvl = pin_oe[sel] & pin_o[sel];
  // ==========
  // Edge timing; first period after a switch is junk, so callers skip it
  always_ff @(posedge aclk) begin
    prev <= lvl;
    since <= (lvl && !prev) ? 1 : since + 1;
    hcnt <= (lvl && !prev) ? 1 : hcnt + int'(lvl);
    if (lvl && !prev) begin
      period <= since;
      high <= hcnt;
      rises <= rises + 1;
    end
    saw_hi <= !clr && (saw_hi || lvl);
    saw_lo <= !clr && (saw_lo || !lvl);
  end
endmodule

// ### tb/tpw_props.sv
// Checker: bus handshakes and pin gating of the PWM timer.
// Assumes it is bound to tpw_pwm_timer and sees only its ports.
`timescale 1ns/1ps
module tpw_props #(
  parameter int NUM_CH = 3  // Channels
) (
  input wire logic aclk,  // Clock
  input wire logic aresetn,  // Reset
  input wire logic s_axi_awvalid,  // AW valid
  input wire logic s_axi_awready,  // AW ready
  input wire logic s_axi_wvalid,  // W valid
  input wire logic s_axi_wready,  // W ready
  input wire logic s_axi_bvalid,  // B valid
  input wire logic s_axi_bready,  // B ready
  input wire logic s_axi_arvalid,  // AR valid
  input wire logic s_axi_arready,  // AR ready
  input wire logic s_axi_rvalid,  // R valid
  input wire logic s_axi_rready,  // R ready
  input wire logic [NUM_CH-1:0] compare_output_pin_o,  // Pins
  input wire logic [NUM_CH-1:0] compare_output_pin_oe  // Enables
);
  // ==========
  // One clock domain, so clock and reset are given once
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  // ==========
  // Properties
  property p_pin_gate; (compare_output_pin_o & ~compare_output_pin_oe) == '0; endproperty
  property p_rst_out; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready
    && compare_output_pin_oe == '0; endproperty
  property p_wr_ans; s_wr |=> s_axi_bvalid; endproperty
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rd_ans; s_rd |=> s_axi_rvalid && !s_axi_arready; endproperty
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin driven while disabled");
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  a_wr_ans: assert property (p_wr_ans) else $error("no write response");
  a_b_done: assert property (p_b_done) else $error("write response not retired");
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  a_r_done: assert property (p_r_done) else $error("read answer not retired");
  a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
endmodule
bind tpw_pwm_timer tpw_props #(.NUM_CH(NUM_CH)) u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .compare_output_pin_o(compare_output_pin_o),
  .compare_output_pin_oe(compare_output_pin_oe));
